//--- inc/dau_flags_defs.svh
// Offsets, bit positions, reset values and field constants of the status-flag block
`ifndef DAU_FLAGS_DEFS_SVH
`define DAU_FLAGS_DEFS_SVH
// Register byte addresses
`define STATUS_WORD_ADDR 8'h00
`define IRQ_STATUS_ADDR 8'h04
`define IRQ_MASK_ADDR 8'h08
`define ADDR_BITS 8
// Status word bit positions
`define BIT_NEG 15
`define BIT_ZERO 14
`define BIT_LOV 13
`define BIT_MOV 12
`define BIT_SLOV 11
`define BIT_SMOV 10
`define BIT_A1OV 9
`define BIT_A1G_HI 8
`define BIT_A1G_LO 5
`define BIT_A0OV 4
`define BIT_A0G_HI 3
`define BIT_A0G_LO 0
// Reset values
`define STATUS_RESET 16'h0000
`define IRQ_RESET 4'h0
// Interrupt event bit positions
`define EV_LOV 0
`define EV_MOV 1
`define EV_A0OV 2
`define EV_A1OV 3
// Result widths
`define RES_BITS 41
`define GUARD_BITS 4
`endif

//--- inc/dau_flags_pkg.sv
// Types shared by the status-flag block
package dau_flags_pkg;
  // Source unit of a completed operation
  typedef enum logic [2:0] {
    SRC_ALU = 3'b001,
    SRC_ADDER = 3'b010,
    SRC_BMU = 3'b100
  } src_type;
  // Destination accumulator
  typedef enum logic [1:0] {
    DST_NONE = 2'b00,
    DST_ACC0 = 2'b01,
    DST_ACC1 = 2'b10
  } dst_type;
  // One unit's report of a finished operation
  typedef struct packed {
    logic valid;
    logic [40:0] result;
    logic ovf40;
    logic ovf32;
    logic ctlRange;
  } unit_res_type;
  // Derived flags of one operation
  typedef struct packed {
    logic neg;
    logic zero;
    logic lov;
    logic mov;
  } flags_type;
  // Bus state
  typedef struct packed {
    logic pend;
    logic write;
    logic [7:0] addr;
  } bus_type;
  // AHB-Lite read/response outputs
  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
  } resp_type;
  // Whole state of the top module
  typedef struct packed {
    logic [15:0] status;
    logic [3:0] irqStat;
    logic [3:0] irqMask;
    logic irq;
    bus_type bus;
    resp_type resp;
  } state_type;
endpackage

//--- rtl/flag_source_sel.sv
// Selects the flag source among the three units and derives the flags
`include "dau_flags_defs.svh"
`default_nettype none
module flag_source_sel
  import dau_flags_pkg::*;
(
  input wire unit_res_type aluRes,
  input wire unit_res_type adderRes,
  input wire unit_res_type bmuRes,
  output logic done,
  output flags_type flags
);
  // Selected result
  unit_res_type sel;

  // ALU has priority, then adder, then BIT_MANIPULATION_UNIT
  always_comb begin
    if (aluRes.valid) begin
      sel = aluRes;
    end else if (adderRes.valid) begin
      sel = adderRes;
    end else begin
      sel = bmuRes;
    end
    done = sel.valid;
    flags.neg = sel.result[`RES_BITS-1];
    flags.zero = (sel.result == '0);
    // BIT_MANIPULATION_UNIT has no 40-bit limit, only the control range check
    flags.lov = (aluRes.valid || adderRes.valid) ? sel.ovf40 : sel.ctlRange;
    flags.mov = sel.ovf32;
  end
endmodule
`default_nettype wire

//--- rtl/dau_status_flags.sv
// Status-flag logic of the data arithmetic unit with AHB-Lite register access
// Summary of operation
// - ALU result first, else adder or BIT_MANIPULATION_UNIT
// - Bit 15 shows negative result
// - Bit 14 shows zero result
// - Bit 13 shows 40-bit or control overflow
// - Bit 12 shows 32-bit overflow
// - Bit 11 sticky logical overflow, write of zero clears
// - Bit 10 sticky math overflow, write of zero clears
// - Bit 9 accumulator one overflow unsaturated
// - Bit 4 accumulator zero overflow unsaturated
// - Guard bits of both accumulators mapped
`include "dau_flags_defs.svh"
`default_nettype none
module dau_status_flags
  import dau_flags_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire unit_res_type aluRes,
  input wire unit_res_type adderRes,
  input wire unit_res_type bmuRes,
  input wire dst_type dest,
  input wire logic saturationEnableField,
  input wire logic [3:0] accOneLowGuardBits,
  input wire logic [3:0] accZeroLowGuardBits,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  output logic [15:0] statusWord
);
  ////////////////////////////////////////////////////////////////////////////
  // Flag derivation
  // Purely combinational pick of the reporting unit
  // Priority lives in the selector so the top stays flat
  // A unit that reports nothing leaves every flag alone
  // Only one operation is expected per cycle from the core
  // Simultaneous reports still resolve, ALU first
  logic opDone; // A unit finished this cycle
  flags_type newFlags; // Flags of that operation
  flag_source_sel srcSel (
    .aluRes(aluRes),
    .adderRes(adderRes),
    .bmuRes(bmuRes),
    .done(opDone),
    .flags(newFlags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  // Whole block state in one packed word
  // Status, interrupt status, mask and bus pipeline together
  // One next-state copy keeps every update path in one place
  // Ordering of the updates below sets which source wins
  // Software first, hardware events after, guard view last
  // Bus address phase is captured for the following data phase
  state_type s_q; // Registered state
  state_type s_d; // Next state
  logic addrPhase; // Valid transfer address phase
  logic wrStatus; // Data-phase write to the status word
  logic rdIrq; // Data-phase read of interrupt status
  logic a0Ov; // Accumulator zero overflow event
  logic a1Ov; // Accumulator one overflow event
  logic [3:0] events; // Interrupt events this cycle

  always_comb begin
    s_d = s_q;
    addrPhase = hsel && hready && htrans[1];
    wrStatus = s_q.bus.pend && s_q.bus.write && (s_q.bus.addr == `STATUS_WORD_ADDR);
    rdIrq = s_q.bus.pend && !s_q.bus.write && (s_q.bus.addr == `IRQ_STATUS_ADDR);
    // Saturation suppresses the accumulator overflow flags
    a0Ov = opDone && newFlags.mov && dest == DST_ACC0 && !saturationEnableField;
    a1Ov = opDone && newFlags.mov && dest == DST_ACC1 && !saturationEnableField;
    events = '0;
    events[`EV_LOV] = opDone && newFlags.lov;
    events[`EV_MOV] = opDone && newFlags.mov;
    events[`EV_A0OV] = a0Ov;
    events[`EV_A1OV] = a1Ov;
    // Software write takes whole word first, hardware events then win
    if (wrStatus) begin
      s_d.status = s_q.bus.pend ? hwdata[15:0] : s_q.status;
    end
    // Result flags move only on a completed operation or a status-word write
    if (opDone) begin
      s_d.status[`BIT_NEG] = newFlags.neg;
      s_d.status[`BIT_ZERO] = newFlags.zero;
      s_d.status[`BIT_LOV] = newFlags.lov;
      s_d.status[`BIT_MOV] = newFlags.mov;
      if (newFlags.lov) begin
        s_d.status[`BIT_SLOV] = 1'b1;
      end
      if (newFlags.mov) begin
        s_d.status[`BIT_SMOV] = 1'b1;
      end
    end
    if (a1Ov) begin
      s_d.status[`BIT_A1OV] = 1'b1;
    end
    if (a0Ov) begin
      s_d.status[`BIT_A0OV] = 1'b1;
    end
    // Guard bits are a live view of the accumulators
    s_d.status[`BIT_A1G_HI:`BIT_A1G_LO] = accOneLowGuardBits;
    s_d.status[`BIT_A0G_HI:`BIT_A0G_LO] = accZeroLowGuardBits;
    // Interrupt status: read clears, new event wins
    if (rdIrq) begin
      s_d.irqStat = '0;
    end
    s_d.irqStat = s_d.irqStat | events;
    if (s_q.bus.pend && s_q.bus.write && s_q.bus.addr == `IRQ_MASK_ADDR) begin
      s_d.irqMask = hwdata[3:0];
    end
    s_d.irq = |(s_d.irqStat & s_d.irqMask);
    // Read data for the upcoming data phase, zero-wait slave
    s_d.resp.ready = 1'b1;
    s_d.resp.rdata = '0;
    s_d.bus.pend = addrPhase;
    s_d.bus.write = hwrite;
    s_d.bus.addr = haddr[7:0];
    if (addrPhase && !hwrite) begin
      case (haddr[7:0])
        `STATUS_WORD_ADDR: begin
          s_d.resp.rdata = {16'h0000, s_d.status};
        end
        `IRQ_STATUS_ADDR: begin
          s_d.resp.rdata = {28'h000_0000, s_d.irqStat};
        end
        `IRQ_MASK_ADDR: begin
          s_d.resp.rdata = {28'h000_0000, s_d.irqMask};
        end
        default: begin
          s_d.resp.rdata = '0; // Unmapped reads zero
        end
      endcase
    end
  end

  // Single state register
  // Asynchronous clear loads constants only
  // Ready comes out of reset high: the slave never stalls
  // No clock enable, every edge registers the next copy
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{status: `STATUS_RESET, irqStat: `IRQ_RESET, irqMask: `IRQ_RESET,
               irq: 1'b0, bus: '0, resp: '{rdata: 32'h0000_0000, ready: 1'b1}};
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  // No logic between the state register and the pins
  // Response is tied to OKAY: no access is ever refused
  // Flags therefore lag the finishing operation by one cycle
  assign hrdata = s_q.resp.rdata;
  assign hreadyout = s_q.resp.ready;
  assign hresp = 1'b0;
  assign irq = s_q.irq;
  assign statusWord = s_q.status;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Each property but p_readyHigh watches the registered status word
  // Antecedents sample unit reports one cycle earlier
  // Software writes are excluded where they may move a bit
  // Held bits are checked against their own earlier value
  // Sticky bits must never drop without a write
  // Accumulator zero bit must never rise with saturation on
  // Bus checks cover the zero-wait, always-okay slave
  // Disabled while reset is low, so reset values are free
  property p_negFlag;
    @(posedge mclk) disable iff (!rstn) opDone |=> statusWord[15] == $past(newFlags.neg);
  endproperty
  a_negFlag: assert property (p_negFlag) else $error("negative flag wrong");

  property p_zeroFlag;
    @(posedge mclk) disable iff (!rstn) opDone |=> statusWord[14] == $past(newFlags.zero);
  endproperty
  a_zeroFlag: assert property (p_zeroFlag) else $error("zero flag wrong");

  property p_lovFlag;
    @(posedge mclk) disable iff (!rstn)
      (aluRes.valid && aluRes.ovf40) |=> statusWord[13];
  endproperty
  a_lovFlag: assert property (p_lovFlag) else $error("logical overflow missed");

  property p_movFlag;
    @(posedge mclk) disable iff (!rstn)
      (opDone && newFlags.mov) |=> statusWord[12] && statusWord[10];
  endproperty
  a_movFlag: assert property (p_movFlag) else $error("math overflow missed");

  property p_stickyLov;
    @(posedge mclk) disable iff (!rstn)
      (statusWord[11] && !wrStatus) |=> statusWord[11];
  endproperty
  a_stickyLov: assert property (p_stickyLov) else $error("sticky lov dropped");

  property p_stickyMov;
    @(posedge mclk) disable iff (!rstn)
      (!statusWord[10] && !(opDone && newFlags.mov) && !wrStatus) |=> !statusWord[10];
  endproperty
  a_stickyMov: assert property (p_stickyMov) else $error("sticky mov set alone");

  property p_acc1Ov;
    @(posedge mclk) disable iff (!rstn)
      (opDone && newFlags.mov && dest == DST_ACC1 && !saturationEnableField) |=> statusWord[9];
  endproperty
  a_acc1Ov: assert property (p_acc1Ov) else $error("acc one overflow missed");

  property p_acc0Ov;
    @(posedge mclk) disable iff (!rstn)
      (opDone && newFlags.mov && dest == DST_ACC0 && !saturationEnableField) |=> statusWord[4];
  endproperty
  a_acc0Ov: assert property (p_acc0Ov) else $error("acc zero overflow missed");

  property p_guard;
    @(posedge mclk) disable iff (!rstn)
      1'b1 |=> statusWord[8:5] == $past(accOneLowGuardBits)
        && statusWord[3:0] == $past(accZeroLowGuardBits);
  endproperty
  a_guard: assert property (p_guard) else $error("guard bits wrong");

  property p_hold;
    @(posedge mclk) disable iff (!rstn)
      (!opDone && !wrStatus) |=> $stable(statusWord[15:12]);
  endproperty
  a_hold: assert property (p_hold) else $error("result flags moved");

  property p_aluFirst;
    @(posedge mclk) disable iff (!rstn)
      aluRes.valid |=> statusWord[14] == ($past(aluRes.result) == '0);
  endproperty
  a_aluFirst: assert property (p_aluFirst) else $error("ALU result not chosen");

  property p_lovAdder;
    @(posedge mclk) disable iff (!rstn)
      (adderRes.valid && !aluRes.valid && adderRes.ovf40) |=> statusWord[13];
  endproperty
  a_lovAdder: assert property (p_lovAdder) else $error("adder overflow missed");

  property p_lovBmu;
    @(posedge mclk) disable iff (!rstn)
      (bmuRes.valid && !aluRes.valid && !adderRes.valid)
        |=> statusWord[13] == $past(bmuRes.ctlRange);
  endproperty
  a_lovBmu: assert property (p_lovBmu) else $error("control range flag wrong");

  property p_movClear;
    @(posedge mclk) disable iff (!rstn)
      (opDone && !newFlags.mov) |=> !statusWord[12];
  endproperty
  a_movClear: assert property (p_movClear) else $error("math overflow stuck");

  property p_stickyLovSet;
    @(posedge mclk) disable iff (!rstn)
      (opDone && newFlags.lov) |=> statusWord[11];
  endproperty
  a_stickyLovSet: assert property (p_stickyLovSet) else $error("sticky lov not set");

  property p_writeLoad;
    @(posedge mclk) disable iff (!rstn)
      (wrStatus && !opDone) |=> statusWord[11] == $past(hwdata[11]);
  endproperty
  a_writeLoad: assert property (p_writeLoad) else $error("status write lost");

  property p_stickyMovKeep;
    @(posedge mclk) disable iff (!rstn)
      (statusWord[10] && !wrStatus) |=> statusWord[10];
  endproperty
  a_stickyMovKeep: assert property (p_stickyMovKeep) else $error("sticky mov dropped");

  property p_acc1Keep;
    @(posedge mclk) disable iff (!rstn)
      (statusWord[9] && !wrStatus) |=> statusWord[9];
  endproperty
  a_acc1Keep: assert property (p_acc1Keep) else $error("acc one flag dropped");

  property p_acc0Sat;
    @(posedge mclk) disable iff (!rstn)
      (!statusWord[4] && !wrStatus && saturationEnableField) |=> !statusWord[4];
  endproperty
  a_acc0Sat: assert property (p_acc0Sat) else $error("acc zero flag under saturation");

  property p_readyHigh;
    @(posedge mclk) disable iff (!rstn)
      1'b1 |-> hreadyout && !hresp;
  endproperty
  a_readyHigh: assert property (p_readyHigh) else $error("slave stalled or refused");
endmodule
`default_nettype wire

//--- verification/dau_status_flags_tb_top.sv
// Self-checking bench of the status-flag block
`include "dau_flags_defs.svh"
`default_nettype none
module dau_status_flags_tb_top
  import dau_flags_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // One table case: unit, result, {ovf40,ovf32,ctl}, dest, saturation, word
  typedef struct packed {
    src_type src;
    logic [40:0] res;
    logic [2:0] ovf;
    dst_type dst;
    logic sat;
    logic [15:0] exp;
  } row_type;
  localparam row_type ROWS [9] = '{
    '{SRC_ALU, 41'h1, 3'h0, DST_NONE, 1'h0, 16'h0000},
    '{SRC_ALU, 41'h0, 3'h0, DST_NONE, 1'h0, 16'h4000},
    '{SRC_ADDER, 41'h100_0000_0000, 3'h4, DST_NONE, 1'h0, 16'hA800},
    '{SRC_BMU, 41'h1, 3'h1, DST_NONE, 1'h0, 16'h2800},
    '{SRC_BMU, 41'h1, 3'h4, DST_NONE, 1'h0, 16'h0000},
    '{SRC_ALU, 41'h1, 3'h1, DST_NONE, 1'h0, 16'h0000},
    '{SRC_BMU, 41'h1, 3'h2, DST_ACC0, 1'h0, 16'h1410},
    '{SRC_ALU, 41'h1, 3'h2, DST_ACC1, 1'h0, 16'h1600},
    '{SRC_ADDER, 41'h1, 3'h2, DST_ACC1, 1'h1, 16'h1400}
  };
  logic mclk = 1'h0;
  logic rstn;
  unit_res_type aluRes, adderRes, bmuRes;
  dst_type dest;
  logic satEn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [3:0] guardOne, guardZero;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] statusWord;
  int nFail = 0;
  int checkCount = 0;
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #50 mclk = ~mclk;
  dau_status_flags dut (.mclk, .rstn, .aluRes, .adderRes, .bmuRes, .dest,
    .saturationEnableField(satEn), .accOneLowGuardBits(guardOne),
    .accZeroLowGuardBits(guardZero), .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .irq, .statusWord);
  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checkCount++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t ns: %s", $time, m);
      nFail++;
    end
  endtask
  // Counts, verdict, end of run
  task automatic testDone();
    $display("Comparisons %0d, mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Hold until ready is seen high at a falling edge; data taken there, then on to the rising edge
  task automatic waitRdy(output logic [31:0] rd);
    @(negedge mclk);
    while (hreadyout !== 1'h1) @(negedge mclk);
    rd = hrdata;
    @(posedge mclk);
  endtask
  // One single word transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge mclk);
    hsel <= 1'h1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    waitRdy(rd);
    htrans <= 2'h0;
    hwdata <= wd;
    waitRdy(rd);
    hsel <= 1'h0;
  endtask
  // One-cycle completion pulse, then look after the flag update
  task automatic op(input unit_res_type a, input unit_res_type b,
                    input unit_res_type c, input dst_type d, input logic s);
    @(posedge mclk);
    aluRes <= a;
    adderRes <= b;
    bmuRes <= c;
    dest <= d;
    satEn <= s;
    @(posedge mclk);
    aluRes <= '0;
    adderRes <= '0;
    bmuRes <= '0;
    @(negedge mclk);
  endtask
  function automatic unit_res_type u(input logic [40:0] r, input logic [2:0] f);
    return {1'h1, r, f};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: whole run is about a hundred cycles
  initial begin
    #(3000 * 100);
    nFail++;
    testDone();
  end
  // Main sequence
  initial begin
    logic [31:0] rd;
    unit_res_type x;
    {aluRes, adderRes, bmuRes, satEn, guardOne, guardZero} = '0;
    {hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
    dest = DST_NONE;
    rstn = 1'h0;
    repeat (10) @(posedge mclk);
    chk(statusWord, 32'h0, "status after reset");
    chk({hreadyout, hresp, irq}, 32'h4, "bus outputs after reset");
    rstn <= 1'h1;
    $display("Done: reset");
    // Table cases, word cleared by a write before each
    foreach (ROWS[i]) begin
      bus(1'h1, `STATUS_WORD_ADDR, 32'h0, rd);
      x = u(ROWS[i].res, ROWS[i].ovf);
      op(ROWS[i].src[0] ? x : '0, ROWS[i].src[1] ? x : '0, ROWS[i].src[2] ? x : '0,
         ROWS[i].dst, ROWS[i].sat);
      chk(statusWord, ROWS[i].exp, "table flags");
    end
    repeat (5) @(negedge mclk);
    chk(statusWord, 32'h1400, "flags held while idle");
    $display("Done: table");
    // Sticky bits outlive a clean operation, then a write clears them
    bus(1'h1, `STATUS_WORD_ADDR, 32'h0, rd);
    op(u(41'h0, 3'h6), '0, '0, DST_NONE, 1'h0);
    op(u(41'h1, 3'h0), '0, '0, DST_NONE, 1'h0);
    chk(statusWord, 32'h0C00, "sticky kept");
    bus(1'h1, `STATUS_WORD_ADDR, 32'h0, rd);
    @(negedge mclk);
    chk(statusWord, 32'h0, "sticky cleared by write");
    // All three units at once: first unit wins
    op(u(41'h0, 3'h0), u(41'h100_0000_0000, 3'h6), u(41'h1, 3'h1), DST_NONE, 1'h0);
    chk(statusWord, 32'h4000, "first unit has priority");
    bus(1'h1, 8'h0C, 32'hFFFF_FFFF, rd);
    bus(1'h0, 8'h0C, 32'h0, rd);
    chk(rd, 32'h0, "unmapped read");
    chk(statusWord, 32'h4000, "unmapped write ignored");
    $display("Done: sticky and priority");
    // Guard bits mirror the accumulators; write loads only flag bits
    @(posedge mclk);
    guardOne <= 4'hA;
    guardZero <= 4'h5;
    bus(1'h1, `STATUS_WORD_ADDR, 32'h0000_FFFF, rd);
    @(negedge mclk);
    chk(statusWord, 32'hFF55, "write load and guard view");
    bus(1'h0, `STATUS_WORD_ADDR, 32'h0, rd);
    chk(rd, 32'h0000_FF55, "status word read");
    $display("Done: guard bits");
    // Interrupt: clear, mask, raise, read-clear
    bus(1'h0, `IRQ_STATUS_ADDR, 32'h0, rd);
    bus(1'h1, `IRQ_MASK_ADDR, 32'h2, rd);
    bus(1'h0, `IRQ_MASK_ADDR, 32'h0, rd);
    chk(rd, 32'h2, "mask read back");
    op(u(41'h1, 3'h4), '0, '0, DST_NONE, 1'h0);
    @(negedge mclk);
    chk(irq, 32'h0, "masked event quiet");
    op(u(41'h1, 3'h2), '0, '0, DST_NONE, 1'h0);
    @(negedge mclk);
    chk(irq, 32'h1, "unmasked event raises");
    bus(1'h0, `IRQ_STATUS_ADDR, 32'h0, rd);
    chk(rd, 32'h3, "event status");
    repeat (2) @(negedge mclk);
    chk(irq, 32'h0, "irq drops after read");
    bus(1'h0, `IRQ_STATUS_ADDR, 32'h0, rd);
    chk(rd, 32'h0, "status cleared by read");
    $display("Done: interrupt");
    testDone();
  end
endmodule
`default_nettype wire
